// File: stiic_core.sv
// per-port packet integrity logic: head-of-queue time-outs, end-to-end parity, attribute forcing
// Contract
// - with time-out enabled, discard head packets older than 50 ms; off after reset
// - a time-out discard sets the status bit of the packet's type
// - a time-out discard bumps a saturating per-type count; reading clears it atomically
// - time-out messages follow per-type policy, gated by system-error and severity enables
// - one time-out message per status rise; none again until cleared and set
// - reset policy: posted and inserted report nonfatal; non-posted and completion silent
// - a time-out during a broadcast packet aborts it, maybe partly sent
// - ingress checks link crc, makes dword parity; crc error forces partner resend
// - changes inside the switch update parity incrementally, never regenerate it
// - egress checks parity while computing outgoing crc; clean packets send that crc inverted
// - egress parity error nullifies: the computed crc sent uninverted and an edb ending
// - a parity error sets parity status and bumps a saturating clear-on-read count
// - packet memories are parity protected; their errors surface via end-to-end check
// - one parity message per status rise when enabled; no repeat until cleared
// - check disable suppresses parity checking only; generation always stays on
// - injection inverts parity of every dword when header length matches programmed length
// - reset: parity checking on, errors reported as nonfatal
// - switch-made packets get parity at birth; consumed ones are checked, bad ones dropped
// - forced relaxed ordering overwrites that attribute except config, io and message requests
// - forced no snoop overwrites that attribute with the same exclusions
`timescale 1ns/100ps
module stiic_core #(
  parameter int unsigned MS_CYCLES = stiic_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hoq_check_i,
  input wire stiic_pkg::stiic_kind_e hoq_kind_i,
  input wire logic [stiic_pkg::STAMP_W-1:0] hoq_stamp_i,
  input wire logic hoq_broadcast_i,
  output logic [stiic_pkg::STAMP_W-1:0] entry_stamp_o,
  output logic hoq_discard_o,
  output logic hoq_pass_o,
  output logic bcast_abort_o,
  input wire logic rx_valid_i,
  input wire logic rx_sop_i,
  input wire logic rx_eop_i,
  input wire logic [31:0] rx_data_i,
  input wire logic rx_lcrc_err_i,
  output logic retry_req_o,
  output logic core_valid_o,
  output logic core_sop_o,
  output logic core_eop_o,
  output logic [31:0] core_data_o,
  output logic core_par_o,
  output logic core_drop_o,
  input wire logic loc_valid_i,
  input wire logic [31:0] loc_data_i,
  output logic loc_valid_o,
  output logic [31:0] loc_data_o,
  output logic loc_par_o,
  input wire logic eg_valid_i,
  input wire logic eg_sop_i,
  input wire logic eg_eop_i,
  input wire logic [31:0] eg_data_i,
  input wire logic eg_par_i,
  input wire logic eg_consume_i,
  output logic tx_valid_o,
  output logic tx_sop_o,
  output logic tx_eop_o,
  output logic [31:0] tx_data_o,
  output logic [31:0] tx_lcrc_o,
  output logic tx_edb_o,
  output logic consume_ok_o,
  output logic consume_discard_o,
  output logic err_msg_valid_o,
  output stiic_pkg::stiic_sev_e err_msg_sev_o
);
  import stiic_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic timeout_enable_bit;
  logic [3:0] timeout_status_reg;
  logic [CNT_W-1:0] to_cnt [4];
  logic [7:0] timeout_report_control_reg;
  logic system_error_enable;
  logic [3:0] dev_en;
  logic parity_error_status_bit;
  logic [CNT_W-1:0] parity_error_count_field;
  logic [1:0] parity_report_control_reg;
  logic parity_check_disable;
  logic bad_parity_inject;
  logic [LEN_W-1:0] inject_len;
  logic [3:0] packet_processing_control_reg;

  logic [TICK_W-1:0] tick_cnt;
  logic [STAMP_W-1:0] ms_now;
  logic inj_hold;
  logic eg_err_seen;
  logic [4:0] msg_pend;

  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_mux;
  logic [31:0] wr_word;
  logic [31:0] clr_word;
  logic [STAMP_W-1:0] age;
  logic expired;
  logic [3:0] to_set;
  logic pe_event;
  logic inj_match;
  logic [31:0] rx_mod;
  logic rx_par;
  logic eg_bad_now;
  logic eg_pkt_bad;
  logic [31:0] crc_next;
  logic [4:0] new_pend;
  logic [4:0] grant;

  // ----------------------------------------------------------------
  // wishbone classic slave: ack one cycle after the strobe, then drop
  // ----------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i;
  assign rd_en = bus_req & ~wb_we_i;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    lane_merge = old;
  endfunction

  function automatic logic [31:0] w1c_mask(input logic [31:0] d, input logic [3:0] sel);
    w1c_mask = lane_merge(32'h00000000, d, sel);
  endfunction

  // written lanes merged over the current value, so unselected bytes keep their contents
  assign wr_word = lane_merge(rd_mux, wb_dat_i, wb_sel_i);
  assign clr_word = w1c_mask(wb_dat_i, wb_sel_i);

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (wb_adr_i)
      TO_CTL_OFS: rd_mux[TO_EN_BIT] = timeout_enable_bit;
      TO_STS_OFS: rd_mux[3:0] = timeout_status_reg;
      TO_CNT_OFS: rd_mux = {to_cnt[3], to_cnt[2], to_cnt[1], to_cnt[0]};
      TO_RCTL_OFS: rd_mux[7:0] = timeout_report_control_reg;
      BR_CMD_OFS: rd_mux[SERR_EN_BIT] = system_error_enable;
      DEV_CTL_OFS: rd_mux[3:0] = dev_en;
      PE_STS_OFS: rd_mux[0] = parity_error_status_bit;
      PE_CNT_OFS: rd_mux[CNT_W-1:0] = parity_error_count_field;
      PE_RCTL_OFS: rd_mux[1:0] = parity_report_control_reg;
      PE_CTL_OFS: begin
        rd_mux[PCHK_DIS_BIT] = parity_check_disable;
        rd_mux[PINJ_BIT] = bad_parity_inject;
        rd_mux[PLEN_LSB +: LEN_W] = inject_len;
      end
      PP_CTL_OFS: rd_mux[3:0] = packet_processing_control_reg;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_en ? rd_mux : 32'h00000000;
    end
  end

  // plain read-write control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_enable_bit <= 1'b0;
      timeout_report_control_reg <= TO_RCTL_RST;
      system_error_enable <= 1'b0;
      dev_en <= 4'h0;
      parity_report_control_reg <= PE_RCTL_RST;
      parity_check_disable <= 1'b0;
      bad_parity_inject <= 1'b0;
      inject_len <= 10'h000;
      packet_processing_control_reg <= 4'h0;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        TO_CTL_OFS: timeout_enable_bit <= wr_word[TO_EN_BIT];
        TO_RCTL_OFS: timeout_report_control_reg <= wr_word[7:0];
        BR_CMD_OFS: system_error_enable <= wr_word[SERR_EN_BIT];
        DEV_CTL_OFS: dev_en <= wr_word[3:0];
        PE_RCTL_OFS: parity_report_control_reg <= wr_word[1:0];
        PE_CTL_OFS: begin
          parity_check_disable <= wb_sel_i[0] ? wb_dat_i[PCHK_DIS_BIT] : parity_check_disable;
          bad_parity_inject <= wb_sel_i[0] ? wb_dat_i[PINJ_BIT] : bad_parity_inject;
          inject_len[7:0] <= wb_sel_i[2] ? wb_dat_i[PLEN_LSB +: 8] : inject_len[7:0];
          inject_len[9:8] <= wb_sel_i[3] ? wb_dat_i[PLEN_LSB+8 +: 2] : inject_len[9:8];
        end
        PP_CTL_OFS: packet_processing_control_reg <= wr_word[3:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // time base and head-of-queue age check
  // ----------------------------------------------------------------
  // the 8-bit stamp wraps after 256 ms; a packet held longer than that can alias young
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
      ms_now <= '0;
      entry_stamp_o <= '0;
    end else begin
      if (tick_cnt == TICK_W'(MS_CYCLES - 1)) begin
        tick_cnt <= '0;
        ms_now <= ms_now + 8'h01;
      end else begin
        tick_cnt <= tick_cnt + 18'h00001;
      end
      entry_stamp_o <= ms_now;
    end
  end

  assign age = ms_now - hoq_stamp_i;
  assign expired = hoq_check_i & timeout_enable_bit & (age > STAMP_W'(TIMEOUT_MS));

  always_comb begin
    to_set = 4'h0;
    to_set[hoq_kind_i] = expired;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hoq_discard_o <= 1'b0;
      hoq_pass_o <= 1'b0;
      bcast_abort_o <= 1'b0;
    end else begin
      hoq_discard_o <= expired;
      hoq_pass_o <= hoq_check_i & ~expired;
      bcast_abort_o <= expired & hoq_broadcast_i;
    end
  end

  // ----------------------------------------------------------------
  // status and counts: hardware set wins over a same-cycle clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_status_reg <= 4'h0;
      parity_error_status_bit <= 1'b0;
    end else begin
      timeout_status_reg <= (timeout_status_reg & ~((wr_en && wb_adr_i == TO_STS_OFS) ?
                            clr_word[3:0] : 4'h0)) | to_set;
      parity_error_status_bit <= (parity_error_status_bit & ~((wr_en && wb_adr_i == PE_STS_OFS) ?
                                 wb_dat_i[0] & wb_sel_i[0] : 1'b0)) | pe_event;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 4; k++) begin
        to_cnt[k] <= '0;
      end
      parity_error_count_field <= '0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        to_cnt[k] <= sat_count(to_cnt[k], to_set[k], rd_en && wb_adr_i == TO_CNT_OFS);
      end
      parity_error_count_field <= sat_count(parity_error_count_field, pe_event,
                                            rd_en && wb_adr_i == PE_CNT_OFS);
    end
  end

  // ----------------------------------------------------------------
  // error messages: one per status rise, queued one per cycle
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      new_pend[k] = to_set[k] & ~timeout_status_reg[k] &
                    sev_allowed(timeout_report_control_reg[k*2 +: 2], system_error_enable, dev_en);
    end
    new_pend[4] = pe_event & ~parity_error_status_bit &
                  sev_allowed(parity_report_control_reg, system_error_enable, dev_en);
    grant = msg_pend & (~msg_pend + 5'h01);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msg_pend <= 5'h00;
      err_msg_valid_o <= 1'b0;
      err_msg_sev_o <= STIIC_SEV_NONE;
    end else begin
      msg_pend <= (msg_pend & ~grant) | new_pend;
      err_msg_valid_o <= |grant;
      err_msg_sev_o <= STIIC_SEV_NONE;
      for (int k = 0; k < 4; k++) begin
        if (grant[k]) begin
          err_msg_sev_o <= stiic_sev_e'(timeout_report_control_reg[k*2 +: 2]);
        end
      end
      if (grant[4]) begin
        err_msg_sev_o <= stiic_sev_e'(parity_report_control_reg);
      end
    end
  end

  // ----------------------------------------------------------------
  // ingress: parity generation, attribute forcing, injection
  // ----------------------------------------------------------------
  assign inj_match = rx_sop_i ? (rx_data_i[LEN_W-1:0] == inject_len) : inj_hold;

  always_comb begin
    rx_mod = rx_data_i;
    if (rx_sop_i && attr_applicable(rx_data_i[HDR_TYPE_LSB +: 5])) begin
      if (packet_processing_control_reg[FRO_BIT]) begin
        rx_mod[HDR_RO_BIT] = packet_processing_control_reg[ROV_BIT];
      end
      if (packet_processing_control_reg[FNS_BIT]) begin
        rx_mod[HDR_NS_BIT] = packet_processing_control_reg[NSV_BIT];
      end
    end
    // parity of the received dword, then patched for each flipped bit so upstream faults survive
    rx_par = dword_parity(rx_data_i) ^ (rx_data_i[HDR_RO_BIT] ^ rx_mod[HDR_RO_BIT]) ^
             (rx_data_i[HDR_NS_BIT] ^ rx_mod[HDR_NS_BIT]) ^ (bad_parity_inject & inj_match);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inj_hold <= 1'b0;
      core_valid_o <= 1'b0;
      core_sop_o <= 1'b0;
      core_eop_o <= 1'b0;
      core_data_o <= 32'h00000000;
      core_par_o <= 1'b0;
      core_drop_o <= 1'b0;
      retry_req_o <= 1'b0;
    end else begin
      if (rx_valid_i && rx_sop_i) begin
        inj_hold <= inj_match;
      end
      core_valid_o <= rx_valid_i;
      core_sop_o <= rx_valid_i & rx_sop_i;
      core_eop_o <= rx_valid_i & rx_eop_i;
      core_data_o <= rx_mod;
      core_par_o <= rx_par;
      core_drop_o <= rx_valid_i & rx_eop_i & rx_lcrc_err_i;
      retry_req_o <= rx_valid_i & rx_eop_i & rx_lcrc_err_i;
    end
  end

  // switch-generated dwords get parity as they are made
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loc_valid_o <= 1'b0;
      loc_data_o <= 32'h00000000;
      loc_par_o <= 1'b0;
    end else begin
      loc_valid_o <= loc_valid_i;
      loc_data_o <= loc_data_i;
      loc_par_o <= dword_parity(loc_data_i);
    end
  end

  // ----------------------------------------------------------------
  // egress: parity check alongside the link crc
  // ----------------------------------------------------------------
  // stored parity travels with the data through every packet memory, so a memory
  // upset shows up here rather than needing its own checker
  assign eg_bad_now = eg_valid_i & (dword_parity(eg_data_i) ^ eg_par_i) & ~parity_check_disable;
  assign eg_pkt_bad = eg_bad_now | (eg_err_seen & ~eg_sop_i);
  assign pe_event = eg_valid_i & eg_eop_i & eg_pkt_bad;

  stiic_lcrc u_lcrc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .valid_i(eg_valid_i),
    .sop_i(eg_sop_i),
    .data_i(eg_data_i),
    .crc_next_o(crc_next)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eg_err_seen <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_sop_o <= 1'b0;
      tx_eop_o <= 1'b0;
      tx_data_o <= 32'h00000000;
      tx_lcrc_o <= 32'h00000000;
      tx_edb_o <= 1'b0;
      consume_ok_o <= 1'b0;
      consume_discard_o <= 1'b0;
    end else begin
      if (eg_valid_i) begin
        eg_err_seen <= eg_pkt_bad & ~eg_eop_i;
      end
      tx_valid_o <= eg_valid_i & ~eg_consume_i;
      tx_sop_o <= eg_valid_i & eg_sop_i & ~eg_consume_i;
      tx_eop_o <= eg_valid_i & eg_eop_i & ~eg_consume_i;
      tx_data_o <= eg_data_i;
      if (eg_valid_i && eg_eop_i && !eg_consume_i) begin
        tx_lcrc_o <= eg_pkt_bad ? crc_next : ~crc_next;
      end
      tx_edb_o <= eg_valid_i & eg_eop_i & ~eg_consume_i & eg_pkt_bad;
      consume_ok_o <= eg_valid_i & eg_eop_i & eg_consume_i & ~eg_pkt_bad;
      consume_discard_o <= eg_valid_i & eg_eop_i & eg_consume_i & eg_pkt_bad;
    end
  end
endmodule

// File: stiic_core_checker.sv
// port assertions for the switch integrity block
`timescale 1ns/100ps
module stiic_core_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic hoq_check_i,
  input wire logic hoq_discard_o,
  input wire logic hoq_pass_o,
  input wire logic bcast_abort_o,
  input wire logic tx_eop_o,
  input wire logic tx_edb_o,
  input wire logic rx_valid_i,
  input wire logic rx_eop_i,
  input wire logic rx_lcrc_err_i,
  input wire logic retry_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_bad_rx; rx_valid_i && rx_eop_i && rx_lcrc_err_i; endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_hoq_answer: assert property (hoq_check_i |=> hoq_discard_o ^ hoq_pass_o) else $error("no verdict");
  a_hoq_quiet: assert property (!hoq_check_i |=> !(hoq_discard_o || hoq_pass_o)) else $error("stray verdict");
  a_abort_discard: assert property (bcast_abort_o |-> hoq_discard_o) else $error("abort alone");
  a_edb_eop: assert property (tx_edb_o |-> tx_eop_o) else $error("edb off end");
  a_retry_crc: assert property (s_bad_rx |=> retry_req_o) else $error("no retry");
  a_retry_cause: assert property (retry_req_o |-> $past(rx_lcrc_err_i && rx_eop_i)) else $error("stray retry");
endmodule

// File: stiic_lcrc.sv
// running 32-bit link crc over one dword per clock
`timescale 1ns/100ps
module stiic_lcrc (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic sop_i,
  input wire logic [31:0] data_i,
  output logic [31:0] crc_next_o
);
  import stiic_pkg::*;

  localparam logic [31:0] POLY = 32'h04C11DB7;
  localparam logic [31:0] SEED = 32'hFFFFFFFF;

  logic [31:0] crc;

  // ----------------------------------------------------------------
  // one dword of crc update
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ POLY) : (r << 1);
    end
    crc_step = r;
  endfunction

  always_comb begin
    crc_next_o = crc_step(sop_i ? SEED : crc, data_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc <= SEED;
    end else if (valid_i) begin
      crc <= crc_next_o;
    end
  end
endmodule

// File: stiic_link_partner.sv
// link partner that takes or drops packets leaving the egress port
`timescale 1ns/100ps
module stiic_link_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tx_valid_i,
  input wire logic tx_eop_i,
  input wire logic tx_edb_i,
  output logic [7:0] good_o,
  output logic [7:0] null_o
);
  // a nullified packet is counted apart and never handed on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      good_o <= '0;
      null_o <= '0;
    end else if (tx_valid_i && tx_eop_i && tx_edb_i) begin
      null_o <= null_o + 8'h01;
    end else if (tx_valid_i && tx_eop_i) begin
      good_o <= good_o + 8'h01;
    end
  end
endmodule

// File: stiic_pkg.sv
// shared constants, register map and helper functions for the switch integrity checks
package stiic_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned MS_CYCLES = NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned TIMEOUT_MS = 50;
  localparam int unsigned STAMP_W = 8;
  localparam int unsigned TICK_W = 18;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TO_CTL_OFS = 8'h00;
  localparam logic [7:0] TO_STS_OFS = 8'h04;
  localparam logic [7:0] TO_CNT_OFS = 8'h08;
  localparam logic [7:0] TO_RCTL_OFS = 8'h0C;
  localparam logic [7:0] BR_CMD_OFS = 8'h10;
  localparam logic [7:0] DEV_CTL_OFS = 8'h14;
  localparam logic [7:0] PE_STS_OFS = 8'h18;
  localparam logic [7:0] PE_CNT_OFS = 8'h1C;
  localparam logic [7:0] PE_RCTL_OFS = 8'h20;
  localparam logic [7:0] PE_CTL_OFS = 8'h24;
  localparam logic [7:0] PP_CTL_OFS = 8'h28;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned TO_EN_BIT = 0;
  localparam int unsigned SERR_EN_BIT = 8;
  localparam int unsigned COR_EN_BIT = 0;
  localparam int unsigned NF_EN_BIT = 1;
  localparam int unsigned FAT_EN_BIT = 2;
  localparam int unsigned UR_EN_BIT = 3;
  localparam int unsigned PCHK_DIS_BIT = 0;
  localparam int unsigned PINJ_BIT = 1;
  localparam int unsigned PLEN_LSB = 16;
  localparam int unsigned LEN_W = 10;
  localparam int unsigned FRO_BIT = 0;
  localparam int unsigned ROV_BIT = 1;
  localparam int unsigned FNS_BIT = 2;
  localparam int unsigned NSV_BIT = 3;
  localparam int unsigned HDR_RO_BIT = 13;
  localparam int unsigned HDR_NS_BIT = 12;
  localparam int unsigned HDR_TYPE_LSB = 24;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] TO_RCTL_RST = 8'h82;
  localparam logic [1:0] PE_RCTL_RST = 2'h2;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STIIC_POSTED = 2'b00,
    STIIC_NONPOSTED = 2'b01,
    STIIC_COMPLETION = 2'b10,
    STIIC_INSERTED = 2'b11
  } stiic_kind_e;

  typedef enum logic [1:0] {
    STIIC_SEV_NONE = 2'b00,
    STIIC_SEV_COR = 2'b01,
    STIIC_SEV_NONFATAL = 2'b10,
    STIIC_SEV_FATAL = 2'b11
  } stiic_sev_e;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // even parity bit: data and parity together hold an even number of ones
  function automatic logic dword_parity(input logic [31:0] d);
    dword_parity = ^d;
  endfunction

  // io (00010), config (0010x) and message (10xxx) requests keep their attributes
  function automatic logic attr_applicable(input logic [4:0] t);
    attr_applicable = !((t == 5'h02) || (t[4:1] == 4'h2) || (t[4:3] == 2'h2));
  endfunction

  // saturating count, cleared by a read; an event in the read cycle survives as one
  function automatic logic [CNT_W-1:0] sat_count(input logic [CNT_W-1:0] c, input logic inc, input logic clr);
    if (clr) begin
      sat_count = inc ? 8'h01 : 8'h00;
    end else if (inc && (c != CNT_MAX)) begin
      sat_count = c + 8'h01;
    end else begin
      sat_count = c;
    end
  endfunction

  // severity allowed through the command and device-control enables
  function automatic logic sev_allowed(input logic [1:0] sev, input logic serr, input logic [3:0] en);
    unique case (sev)
      STIIC_SEV_NONE: sev_allowed = 1'b0;
      STIIC_SEV_COR: sev_allowed = en[COR_EN_BIT];
      STIIC_SEV_NONFATAL: sev_allowed = en[NF_EN_BIT] | serr;
      STIIC_SEV_FATAL: sev_allowed = en[FAT_EN_BIT] | serr;
    endcase
  endfunction

endpackage

// File: test_switch_tlp_integrity_checks.sv
// self-checking bench for the switch integrity block
`timescale 1ns/100ps
`define CK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module test_switch_tlp_integrity_checks;
  import stiic_pkg::*;
  logic clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, hoq_check_i = '0, hoq_broadcast_i = '0;
  logic rx_valid_i = '0, rx_sop_i = '0, rx_eop_i = '0, rx_lcrc_err_i = '0, loc_valid_i = '0, eg_consume_i = '0, rt;
  logic eg_valid_i = '0, eg_sop_i = '0, eg_eop_i = '0, eg_par_i = '0, wb_ack_o, hoq_discard_o, hoq_pass_o, tx_edb_o;
  logic bcast_abort_o, retry_req_o, core_valid_o, core_sop_o, core_eop_o, core_par_o, core_drop_o, loc_valid_o;
  logic loc_par_o, tx_valid_o, tx_sop_o, tx_eop_o, consume_ok_o, consume_discard_o, err_msg_valid_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic [7:0] wb_adr_i = '0, hoq_stamp_i = '0, entry_stamp_o, good, nul, msgs = '0, cons = '0;
  logic [31:0] wb_dat_i = '0, rx_data_i = '0, loc_data_i = '0, eg_data_i = '0, wb_dat_o, core_data_o, loc_data_o;
  logic [31:0] tx_data_o, tx_lcrc_o, rd, lc;
  stiic_kind_e hoq_kind_i = STIIC_POSTED;
  stiic_sev_e err_msg_sev_o, lsev;
  int err_total = 0, total_checks = 0, cyc = 0;
  // a 4-cycle millisecond keeps the 50 ms age inside a short run
  stiic_core #(.MS_CYCLES(4)) DUT (.*);
  stiic_link_partner u_lp (.clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o), .tx_eop_i(tx_eop_o),
    .tx_edb_i(tx_edb_o), .good_o(good), .null_o(nul));
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (err_msg_valid_o === 1'b1) begin
      msgs <= msgs + 8'h01;
      lsev <= err_msg_sev_o;
    end
    cons <= cons + {consume_discard_o === 1'b1, 3'h0, consume_ok_o === 1'b1};
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic wbr(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CK("register", e, rd)
  endtask
  task automatic hq(input stiic_kind_e k, input logic [7:0] age, input logic b, input logic x);
    @(posedge clk_i);
    hoq_kind_i <= k;
    {hoq_check_i, hoq_stamp_i, hoq_broadcast_i} <= {1'b1, entry_stamp_o - age, b};
    @(posedge clk_i);
    hoq_check_i <= 1'b0;
    @(posedge clk_i);
    `CK("verdict", {x, ~x, b & x}, {hoq_discard_o, hoq_pass_o, bcast_abort_o})
  endtask
  task automatic tr(input logic [7:0] m);
    wb(1'b1, TO_STS_OFS, 32'h1);
    hq(STIIC_POSTED, 8'h3C, 1'b0, 1'b1);
    repeat (4) @(posedge clk_i);
    `CK("messages", m, msgs)
  endtask
  task automatic rx(input logic [31:0] d, input logic e, input logic inj);
    @(posedge clk_i);
    {rx_valid_i, rx_sop_i, rx_eop_i, rx_data_i, rx_lcrc_err_i} <= {3'h7, d, e};
    loc_data_i <= d;
    @(posedge clk_i);
    {rx_valid_i, rx_sop_i, rx_eop_i} <= 3'h0;
    @(posedge clk_i);
    rt = retry_req_o;
    `CK("core parity", inj, ^{core_data_o, core_par_o})
    `CK("retry drop", {e, e}, {retry_req_o, core_drop_o})
    `CK("local parity", 1'b0, ^{loc_data_o, loc_par_o})
  endtask
  // two-dword packet; bad flips only the closing dword's parity
  task automatic eg(input logic [31:0] d, input logic bad);
    @(posedge clk_i);
    {eg_valid_i, eg_sop_i, eg_eop_i, eg_data_i, eg_par_i} <= {3'h6, d, ^d};
    @(posedge clk_i);
    {eg_sop_i, eg_eop_i, eg_data_i, eg_par_i} <= {2'h1, ~d, bad ^ (^d)};
    @(posedge clk_i);
    eg_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wbr(TO_RCTL_OFS, 32'h82);
    wbr(PE_RCTL_OFS, 32'h2);
    wbr(PE_CTL_OFS, 32'h0);
    wb(1'b1, DEV_CTL_OFS, 32'h2);
    hq(STIIC_POSTED, 8'h3C, 1'b0, 1'b0);
    wb(1'b1, TO_CTL_OFS, 32'h1);
    hq(STIIC_POSTED, 8'h31, 1'b0, 1'b0);
    hq(STIIC_POSTED, 8'h34, 1'b0, 1'b1);
    hq(STIIC_POSTED, 8'h3C, 1'b0, 1'b1);
    hq(STIIC_NONPOSTED, 8'h3C, 1'b1, 1'b1);
    wbr(TO_STS_OFS, 32'h3);
    wbr(TO_CNT_OFS, 32'h102);
    wbr(TO_CNT_OFS, 32'h0);
    `CK("messages", 8'h1, msgs)
    `CK("severity", STIIC_SEV_NONFATAL, lsev)
    tr(8'h2);
    wb(1'b1, DEV_CTL_OFS, 32'h0);
    tr(8'h2);
    wb(1'b1, BR_CMD_OFS, 32'h100);
    tr(8'h3);
    eg(32'h12345678, 1'b0);
    lc = tx_lcrc_o;
    eg(32'h12345678, 1'b1);
    `CK("link crc", ~lc, tx_lcrc_o)
    wbr(PE_STS_OFS, 32'h1);
    wbr(PE_CNT_OFS, 32'h1);
    eg(32'h12345678, 1'b1);
    wb(1'b1, PE_CTL_OFS, 32'h1);
    eg(32'h12345678, 1'b1);
    `CK("partner", 16'h0202, {good, nul})
    `CK("messages", 8'h4, msgs)
    wb(1'b1, PE_CTL_OFS, 32'h30002);
    wb(1'b1, PP_CTL_OFS, 32'hF);
    rx(32'h3, 1'b0, 1'b1);
    `CK("attributes", 2'h3, core_data_o[13:12])
    rx(32'h04000004, 1'b0, 1'b0);
    `CK("attributes", 2'h0, core_data_o[13:12])
    rx(32'h4, 1'b1, 1'b0);
    `CK("retry", 1'b1, rt)
    rx(32'h4, 1'b0, 1'b0);
    eg_consume_i <= 1'b1;
    eg(32'h12345678, 1'b0);
    eg(32'h12345678, 1'b1);
    eg(32'h12345678, 1'b1);
    `CK("consumed", 24'h210202, {cons, good, nul})
    stop_test();
  end
endmodule
bind stiic_core stiic_core_checker u_chk (.*);
